// *** fsw_consts.vh ***
// fsw_consts.vh: constants for the flash status register and write gating block
`ifndef FSW_CONSTS_VH
`define FSW_CONSTS_VH
// ------------------------------------------------------------
// status register bit positions
// ------------------------------------------------------------
`define FSW_BIT_BUSY 0
`define FSW_BIT_WEL 1
`define FSW_BIT_PL_LO 2
`define FSW_BIT_PL_HI 5
`define FSW_BIT_QE 6
`define FSW_BIT_LOCK 7
`define FSW_STATUS_RESET 8'h00
`define FSW_NV_RESET 6'h00
// ------------------------------------------------------------
// instruction codes
// ------------------------------------------------------------
`define FSW_CMD_SET_WEL 8'h06
`define FSW_CMD_CLR_WEL 8'h04
`define FSW_CMD_WRITE_STATUS_CMD 8'h01
`define FSW_CMD_RDSR 8'h05
`define FSW_CMD_RDERP 8'h81
`define FSW_CMD_RSTEN 8'h66
`define FSW_CMD_RST 8'h99
`define FSW_CMD_SUSPEND 8'h75
`define FSW_CMD_CHIP_ERASE_A 8'hc7
`define FSW_CMD_CHIP_ERASE_B 8'h60
`define FSW_CMD_SET_READ_PARAMS_VOLATILE_ALT 8'hc0
`define FSW_CMD_BANKV_ALT 8'h17
`define FSW_CMD_GANG_LOCK 8'h7e
`define FSW_CMD_GANG_UNLOCK 8'h98
// ------------------------------------------------------------
// operation lengths in base clock cycles
// ------------------------------------------------------------
`define FSW_PROG_CYCLES 2000
`define FSW_ERASE_CYCLES 4000
`define FSW_REG_CYCLES 1000
`endif

// *** fsw_link_sync.v ***
// fsw_link_sync.v: two-stage synchroniser bank for the serial link pins
`timescale 1ns/1ps
module fsw_link_sync #(
   parameter WIDTH = 3
) (
   input wire clock,
   input wire reset,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clock) begin
            if (reset) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
            end else begin
               stage1[i] <= async_in[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate
   assign sync_out = stage2;
endmodule // fsw_link_sync

// *** fsw_status_gate.v ***
// fsw_status_gate.v: status register, busy flag and write enable gating of a serial flash
// How it works
// RULE1: a status read repeats the same byte until chip select returns high; the code reloads the live status at each byte.
// RULE2: status byte holds busy, latch, four protect levels, quad enable, lock; resets zero.
// RULE3: busy is read only, high during the operation, cleared at its end always.
// RULE4: while busy, only status reads and resets are accepted.
// RULE5: suspend is also accepted while a program or erase runs.
// RULE6: the set-latch instruction sets the write enable latch.
// RULE7: the clear-latch instruction clears the write enable latch.
// RULE8: the latch clears itself when a write, program or erase completes; code keeps it after 7Eh, 98h, 63h, 83h, C5h, 4Ah, FBh, E1h, A6h, 91h.
// RULE9: gated write instructions are inhibited while the latch is clear.
// RULE10: a status write keeps the write enable latch set until the write completes, then clears it.
// RULE11: protect levels, quad enable and lock are written by the status write.
// RULE12: the nonvolatile copies of those bits start cleared.
// RULE13: page programs 02h, 32h, 38h need the latch.
// RULE14: four-byte page programs 12h, 34h, 3Eh need the latch.
// RULE15: sector and block erases D7h, 20h, 52h, D8h need the latch.
// RULE16: four-byte erases 21h, 5Ch, DCh need the latch.
// RULE17: whole-array erase C7h or 60h needs the latch.
// RULE18: function register and read-parameter sets 42h, 65h, 63h need the latch.
// RULE19: extended read-parameter sets and information row 85h, 83h, 64h, 62h need it.
// RULE20: bank register writes and learning pattern programs 18h, C5h, 43h, 4Ah need it.
// RULE21: sector protection writes, freeze, gang lock/unlock and password need the latch.
// RULE22: quad enable set drives the quad mode output high.
// RULE23: protect level bits drive the protection level output; zero protects nothing.
// RULE24: alternate codes C0h and 17h run without the latch.
// RULE25: lock set with write protect low makes status writes ignored.
// RULE26: whole-array erase is ignored unless all protect level bits are zero.
// RULE27: a refused gated instruction changes nothing and does not set busy.
`timescale 1ns/1ps
`include "fsw_consts.vh"
module fsw_status_gate #(
   parameter PROG_CYCLES = `FSW_PROG_CYCLES,
   parameter ERASE_CYCLES = `FSW_ERASE_CYCLES,
   parameter REG_CYCLES = `FSW_REG_CYCLES
) (
   input wire CLOCK,
   input wire RESET,
   input wire CHIP_SELECT_N,
   input wire SERIAL_CLOCK,
   input wire SERIAL_IN,
   input wire WRITE_PROTECT_N,
   output reg SERIAL_OUT,
   output reg SERIAL_OUT_ENABLE,
   output wire [7:0] STATUS,
   output wire QUAD_MODE,
   output wire [3:0] PROTECT_LEVEL,
   output reg SUSPEND_PULSE,
   output reg EXEC_PULSE,
   output reg [7:0] EXEC_OPCODE
);
   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function needs_latch;
      input [7:0] op;
      begin
         case (op)
            8'h02, 8'h32, 8'h38: needs_latch = 1'b1; // RULE13
            8'h12, 8'h34, 8'h3e: needs_latch = 1'b1; // RULE14
            8'hd7, 8'h20, 8'h52, 8'hd8: needs_latch = 1'b1; // RULE15
            8'h21, 8'h5c, 8'hdc: needs_latch = 1'b1; // RULE16
            8'hc7, 8'h60: needs_latch = 1'b1; // RULE17
            8'h01, 8'h42, 8'h65, 8'h63: needs_latch = 1'b1; // RULE18
            8'h85, 8'h83, 8'h64, 8'h62: needs_latch = 1'b1; // RULE19
            8'h18, 8'hc5, 8'h43, 8'h4a: needs_latch = 1'b1; // RULE20
            8'hfb, 8'he1, 8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'h91: needs_latch = 1'b1; // RULE21
            8'h7e, 8'h98, 8'he8: needs_latch = 1'b1; // RULE21
            default: needs_latch = 1'b0; // RULE24
         endcase
      end
   endfunction

   // busy duration class: 0 none, 1 program, 2 erase, 3 register write
   function [1:0] op_class;
      input [7:0] op;
      begin
         case (op)
            8'h02, 8'h32, 8'h38, 8'h12, 8'h34, 8'h3e, 8'h62: op_class = 2'd1;
            8'hd7, 8'h20, 8'h52, 8'hd8, 8'h21, 8'h5c, 8'hdc, 8'hc7, 8'h60, 8'h64: op_class = 2'd2;
            8'h01, 8'h42, 8'h65, 8'h85, 8'h18, 8'hfd, 8'he3, 8'he4, 8'h2f, 8'he8: op_class = 2'd3;
            8'h43, 8'h7e, 8'h98: op_class = 2'd3;
            default: op_class = 2'd0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // link sampling and edge finding
   // ------------------------------------------------------------
   wire [3:0] pins_sync;
   fsw_link_sync #(
      .WIDTH(4)
   ) u_sync (
      .clock(CLOCK),
      .reset(RESET),
      .async_in({WRITE_PROTECT_N, SERIAL_IN, SERIAL_CLOCK, ~CHIP_SELECT_N}),
      .sync_out(pins_sync)
   );
   wire cs_active = pins_sync[0];
   wire sck = pins_sync[1];
   wire sdi = pins_sync[2];
   wire wp_n = pins_sync[3];
   reg sck_d;
   reg cs_d;
   wire sck_rise = cs_active & sck & ~sck_d;
   wire sck_fall = cs_active & ~sck & sck_d;
   wire cs_end = cs_d & ~cs_active;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'd0;
   localparam ST_DATA = 2'd1;
   localparam ST_READ = 2'd2;
   localparam ST_DONE = 2'd3;
   reg [1:0] state;
   reg [7:0] shift;
   reg [2:0] bit_cnt;
   reg [7:0] opcode;
   reg [7:0] wr_data;
   reg wr_have;
   reg [7:0] read_byte;
   reg busy;
   reg write_enable_latch;
   reg [5:0] nv_bits;
   reg [1:0] run_class;
   reg [12:0] run_cnt;
   reg clear_wel_at_end;

   assign STATUS = {nv_bits, write_enable_latch, busy}; // RULE2
   assign QUAD_MODE = nv_bits[4]; // RULE22
   assign PROTECT_LEVEL = nv_bits[3:0]; // RULE23

   wire [7:0] shifted = {shift[6:0], sdi};
   wire byte_done = sck_rise & (bit_cnt == 3'd7);
   wire status_locked = nv_bits[5] & ~wp_n; // RULE25

   // an instruction may start only when allowed in the busy state
   function busy_ok;
      input [7:0] op;
      input [1:0] cls;
      begin
         case (op)
            `FSW_CMD_RDSR, `FSW_CMD_RDERP, `FSW_CMD_RSTEN, `FSW_CMD_RST: busy_ok = 1'b1; // RULE4
            `FSW_CMD_SUSPEND: busy_ok = (cls == 2'd1) | (cls == 2'd2); // RULE5
            default: busy_ok = 1'b0;
         endcase
      end
   endfunction

   wire op_ok = ~busy | busy_ok(opcode, run_class);
   wire latch_ok = ~needs_latch(opcode) | write_enable_latch; // RULE9
   wire chip_erase = (opcode == `FSW_CMD_CHIP_ERASE_A) | (opcode == `FSW_CMD_CHIP_ERASE_B);
   wire erase_ok = ~chip_erase | (nv_bits[3:0] == 4'h0); // RULE26
   wire write_status_cmd_ok = (opcode != `FSW_CMD_WRITE_STATUS_CMD) | ~status_locked; // RULE25
   wire accept = op_ok & latch_ok & erase_ok & write_status_cmd_ok; // RULE27
   wire [1:0] cls_now = op_class(opcode);

   // ------------------------------------------------------------
   // serial shifter and instruction capture
   // ------------------------------------------------------------
   always @(posedge CLOCK) begin
      if (RESET) begin
         sck_d <= 1'b0;
         cs_d <= 1'b0;
         state <= ST_IDLE;
         shift <= 8'h00;
         bit_cnt <= 3'd0;
         opcode <= 8'h00;
         wr_data <= 8'h00;
         wr_have <= 1'b0;
         read_byte <= 8'h00;
         SERIAL_OUT <= 1'b0;
         SERIAL_OUT_ENABLE <= 1'b0;
      end else begin
         sck_d <= sck;
         cs_d <= cs_active;
         if (!cs_active) begin
            state <= ST_IDLE;
            bit_cnt <= 3'd0;
            SERIAL_OUT_ENABLE <= 1'b0;
         end else begin
            if (sck_rise) begin
               shift <= shifted;
               bit_cnt <= bit_cnt + 3'd1;
            end
            if (byte_done) begin
               case (state)
                  ST_IDLE: begin
                     opcode <= shifted;
                     wr_have <= 1'b0;
                     if (shifted == `FSW_CMD_RDSR) begin
                        state <= ST_READ;
                        read_byte <= STATUS;
                     end else begin
                        state <= ST_DATA;
                     end
                  end
                  ST_DATA: begin
                     if (!wr_have) begin
                        wr_data <= shifted;
                        wr_have <= 1'b1;
                     end
                     state <= ST_DONE;
                  end
                  ST_READ: begin
                     // reload the live value so a poll sees busy drop
                     read_byte <= STATUS; // RULE1
                  end
                  default: state <= ST_DONE;
               endcase
            end
            if (sck_fall && state == ST_READ) begin
               // wraps at eight bits, so status bytes keep coming until deselect
               SERIAL_OUT <= read_byte[3'd7 - bit_cnt]; // RULE1
               SERIAL_OUT_ENABLE <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // execution at deselect: latch, status write, busy timer
   // ------------------------------------------------------------
   always @(posedge CLOCK) begin
      if (RESET) begin
         busy <= 1'b0;
         write_enable_latch <= 1'b0;
         nv_bits <= `FSW_NV_RESET; // RULE12
         run_class <= 2'd0;
         run_cnt <= 13'd0;
         clear_wel_at_end <= 1'b0;
         SUSPEND_PULSE <= 1'b0;
         EXEC_PULSE <= 1'b0;
         EXEC_OPCODE <= 8'h00;
      end else begin
         SUSPEND_PULSE <= 1'b0;
         EXEC_PULSE <= 1'b0;
         if (busy) begin
            if (run_cnt == 13'd0) begin
               busy <= 1'b0; // RULE3
               run_class <= 2'd0;
               if (clear_wel_at_end)
                  write_enable_latch <= 1'b0; // RULE8
            end else begin
               run_cnt <= run_cnt - 13'd1;
            end
         end
         // instructions end at chip select high; a half-sent one is dropped
         if (cs_end && state != ST_IDLE && accept) begin
            EXEC_PULSE <= 1'b1;
            EXEC_OPCODE <= opcode;
            case (opcode)
               `FSW_CMD_SET_WEL: write_enable_latch <= 1'b1; // RULE6
               `FSW_CMD_CLR_WEL: write_enable_latch <= 1'b0; // RULE7
               `FSW_CMD_SUSPEND: begin
                  // with nothing running there is nothing to suspend
                  if (busy) begin
                     SUSPEND_PULSE <= 1'b1; // RULE5
                     busy <= 1'b0;
                     run_class <= 2'd0;
                  end
               end
               `FSW_CMD_WRITE_STATUS_CMD: begin
                  if (wr_have)
                     nv_bits <= wr_data[7:2]; // RULE11 RULE10
               end
               default: begin
               end
            endcase
            if (cls_now != 2'd0 && !(opcode == `FSW_CMD_WRITE_STATUS_CMD && !wr_have)) begin
               busy <= 1'b1; // RULE3
               run_class <= cls_now;
               // gang lock and unlock keep the latch; nonvolatile ops clear it
               clear_wel_at_end <= (opcode != `FSW_CMD_GANG_LOCK) &&
                  (opcode != `FSW_CMD_GANG_UNLOCK);
               case (cls_now)
                  2'd1: run_cnt <= PROG_CYCLES[12:0];
                  2'd2: run_cnt <= ERASE_CYCLES[12:0];
                  default: run_cnt <= REG_CYCLES[12:0];
               endcase
            end
         end
      end
   end
endmodule // fsw_status_gate

// *** fsw_host_model.sv ***
// fsw_host_model.sv: host serial controller model that frames instructions
`timescale 1ns/1ps
module fsw_host_model (
   input wire clock,
   input wire serial_out,
   output logic chip_select_n,
   output logic serial_clock,
   output logic serial_in
);
   initial begin
      chip_select_n = 1'b1;
      serial_clock = 1'b0;
      serial_in = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // ------------------------------------------------------------
   // one frame, msb first; read bits are taken just before each rise
   // ------------------------------------------------------------
   task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nbytes,
                        output logic [15:0] rd);
      logic [23:0] sh;
      sh = {op, dat, 8'h00};
      rd = 16'h0000;
      tick(1);
      chip_select_n = 1'b0;
      for (int i = 0; i < nbytes * 8; i++) begin
         serial_in = sh[23 - i];
         tick(4);
         rd = {rd[14:0], serial_out};
         serial_clock = 1'b1;
         tick(4);
         serial_clock = 1'b0;
      end
      tick(2);
      chip_select_n = 1'b1;
      // released line must not look like held data
      serial_in = ~serial_in;
      tick(8);
   endtask
endmodule // fsw_host_model

// *** fsw_status_gate_chk.sv ***
// fsw_status_gate_chk.sv: port-level assertions for the status and write gate block
`timescale 1ns/1ps
module fsw_status_gate_chk (
   input wire CLOCK,
   input wire RESET,
   input wire CHIP_SELECT_N,
   input wire SERIAL_CLOCK,
   input wire SERIAL_IN,
   input wire WRITE_PROTECT_N,
   input wire SERIAL_OUT,
   input wire SERIAL_OUT_ENABLE,
   input wire [7:0] STATUS,
   input wire QUAD_MODE,
   input wire [3:0] PROTECT_LEVEL,
   input wire SUSPEND_PULSE,
   input wire EXEC_PULSE,
   input wire [7:0] EXEC_OPCODE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   a_busy_cause: assert property ($rose(STATUS[0]) |-> EXEC_PULSE)
      else $error("busy rose without an accepted instruction");
   a_wel_set: assert property (EXEC_PULSE && EXEC_OPCODE == 8'h06 |-> STATUS[1])
      else $error("latch not set by set command");
   a_wel_clear: assert property (EXEC_PULSE && EXEC_OPCODE == 8'h04 |-> !STATUS[1])
      else $error("latch not cleared by clear command");
   a_wel_rise_src: assert property ($rose(STATUS[1]) |-> EXEC_OPCODE == 8'h06)
      else $error("latch rose by another command");
   a_quad_mirror: assert property (QUAD_MODE == STATUS[6])
      else $error("quad mode differs from status");
   a_level_mirror: assert property (PROTECT_LEVEL == STATUS[5:2])
      else $error("protect level differs from status");
   a_gated_wel: assert property (EXEC_PULSE && EXEC_OPCODE inside {8'h01, 8'h02, 8'h12,
      8'h32, 8'h34, 8'h38, 8'h3e, 8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc,
      8'hc7, 8'h60, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64, 8'h18, 8'hc5, 8'h43,
      8'hfb, 8'he4, 8'h7e, 8'h62, 8'h4a, 8'he1, 8'hfd, 8'he3, 8'h2f, 8'ha6, 8'h91,
      8'h98, 8'he8} |-> $past(STATUS[1]))
      else $error("gated command ran with latch clear");
   a_busy_filter: assert property (EXEC_PULSE && $past(STATUS[0]) |->
      EXEC_OPCODE inside {8'h05, 8'h81, 8'h66, 8'h99, 8'h75})
      else $error("command accepted while busy");
   a_erase_level: assert property (EXEC_PULSE && EXEC_OPCODE inside {8'hc7, 8'h60} |->
      $past(STATUS[5:2]) == 4'h0)
      else $error("whole erase ran with protection set");
   a_suspend_busy: assert property (SUSPEND_PULSE |-> $past(STATUS[0]))
      else $error("suspend taken while idle");
   a_drive_release: assert property ($rose(CHIP_SELECT_N) |-> ##[1:4] !SERIAL_OUT_ENABLE)
      else $error("serial output still driven after deselect");
endmodule // fsw_status_gate_chk
bind fsw_status_gate fsw_status_gate_chk i_chk (.CLOCK, .RESET, .CHIP_SELECT_N,
   .SERIAL_CLOCK, .SERIAL_IN, .WRITE_PROTECT_N, .SERIAL_OUT, .SERIAL_OUT_ENABLE, .STATUS,
   .QUAD_MODE, .PROTECT_LEVEL, .SUSPEND_PULSE, .EXEC_PULSE, .EXEC_OPCODE);

// *** fsw_status_gate_tb.sv ***
// fsw_status_gate_tb.sv: self-checking bench for the status and write gate block
`timescale 1ns/1ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module fsw_status_gate_tb;
   localparam int PROG = 400, ERASE = 600, REG = 10;
   logic clock = 1'b0, reset = 1'b1, wp_n = 1'b1;
   wire cs_n, sck, si, so, so_en, quad, susp, exec;
   wire [7:0] status, opcode;
   wire [3:0] level;
   int miscompares = 0, checks = 0, run = 0, last_run = 0;
   logic [15:0] rd;
   logic [7:0] gated [0:26] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3e, 8'hd7, 8'h20,
      8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83,
      8'h64, 8'h18, 8'hc5, 8'h43, 8'hfb, 8'he4, 8'h7e};
   always #25 clock = ~clock;
   // busy run length, latched at the fall
   always @(posedge clock) begin
      if (status[0] === 1'b1) run <= run + 1;
      else begin
         if (run != 0) last_run <= run;
         run <= 0;
      end
   end
   fsw_status_gate #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE), .REG_CYCLES(REG)) i_fsw_status_gate (
      .CLOCK(clock), .RESET(reset), .CHIP_SELECT_N(cs_n), .SERIAL_CLOCK(sck), .SERIAL_IN(si),
      .WRITE_PROTECT_N(wp_n), .SERIAL_OUT(so), .SERIAL_OUT_ENABLE(so_en), .STATUS(status),
      .QUAD_MODE(quad), .PROTECT_LEVEL(level), .SUSPEND_PULSE(susp), .EXEC_PULSE(exec),
      .EXEC_OPCODE(opcode));
   fsw_host_model i_fsw_host_model (.clock(clock), .serial_out(so), .chip_select_n(cs_n),
      .serial_clock(sck), .serial_in(si));
   task automatic send(input logic [7:0] op, input logic [7:0] dat = 8'h00, input int n = 1);
      i_fsw_host_model.frame(op, dat, n, rd);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (status[0] !== 1'b0 && n < 5000) begin
         @(posedge clock);
         n++;
      end
      @(posedge clock);
      #1;
      if (n >= 5000) miscompares++;
   endtask
   task automatic stop_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #1000000;
      miscompares++;
      stop_test();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      #1 reset = 1'b0;
      repeat (4) @(posedge clock);
      `CMP(status, 8'h00)
      foreach (gated[i]) begin
         send(gated[i]);
         `CMP(status, 8'h00)
      end
      `CMP(opcode, 8'h00)
      send(8'hc0);
      `CMP(opcode, 8'hc0)
      send(8'h17);
      `CMP(opcode, 8'h17)
      $display("test gating done");
      send(8'h06);
      `CMP(status, 8'h02)
      send(8'h04);
      `CMP(status, 8'h00)
      send(8'h06);
      send(8'h01, 8'h5f, 2);
      `CMP(status, 8'h5f)
      wait_idle();
      `CMP(last_run, REG + 1)
      `CMP(status, 8'h5c)
      `CMP(quad, 1'b1)
      `CMP(level, 4'h7)
      send(8'h05, 8'h00, 3);
      `CMP(rd, 16'h5c5c)
      $display("test status write done");
      send(8'h06);
      send(8'h02);
      send(8'h04);
      `CMP(status, 8'h5f)
      send(8'h81);
      `CMP(opcode, 8'h81)
      send(8'h05, 8'h00, 3);
      `CMP(rd, 16'h5f5f)
      `CMP(so_en, 1'b0)
      wait_idle();
      `CMP(last_run, PROG + 1)
      `CMP(status, 8'h5c)
      send(8'h06);
      send(8'hd8);
      `CMP(status[0], 1'b1)
      send(8'h75);
      `CMP(status[0], 1'b0)
      `CMP(opcode, 8'h75)
      send(8'h04);
      $display("test busy done");
      send(8'h06);
      send(8'h01, 8'h84, 2);
      wait_idle();
      `CMP(status, 8'h84)
      wp_n = 1'b0;
      send(8'h06);
      send(8'h01, 8'h00, 2);
      `CMP(status, 8'h86)
      send(8'hc7);
      `CMP(status, 8'h86)
      wp_n = 1'b1;
      send(8'h01, 8'h00, 2);
      wait_idle();
      `CMP(status, 8'h00)
      send(8'h06);
      send(8'h60);
      wait_idle();
      `CMP(last_run, ERASE + 1)
      `CMP(status, 8'h00)
      $display("test lock done");
      stop_test();
   end
endmodule // fsw_status_gate_tb
